// ---- hw/slp_regs.vh ----
// register offsets, field positions, reset values and link constants
`ifndef SLP_REGS_VH
`define SLP_REGS_VH

// serial control port framing
`define SLP_ADDR_W        13
`define SLP_INSTR_BITS    5'd16
`define SLP_LAST_BIT      5'd23
`define SLP_FRAME_BITS    5'd24

// register offsets
`define SLP_ADDR_SYNC     13'h003A
`define SLP_ADDR_LINK1    13'h0060
`define SLP_ADDR_OCTETS   13'h006F
`define SLP_ADDR_KFRAMES  13'h0070
`define SLP_ADDR_CONVS    13'h0071
`define SLP_ADDR_RESCS    13'h0072
`define SLP_ADDR_TOTBITS  13'h0073
`define SLP_ADDR_SAMPLES  13'h0074
`define SLP_ADDR_DENSCW   13'h0075
`define SLP_ADDR_SPARE1   13'h0076
`define SLP_ADDR_SPARE2   13'h0077
`define SLP_ADDR_CHKSUM   13'h0078

// sync control fields
`define SLP_SYNC_MASTER   0
`define SLP_SYNC_DIV_EN   1
`define SLP_SYNC_NEXT     2

// link control one fields
`define SLP_L1_PD         0
`define SLP_L1_FA_DIS     1
`define SLP_L1_LANE_SYNC  4
`define SLP_L1_TEST       5
`define SLP_L1_TAIL       6

// reset and fixed values
`define SLP_RST_SYNC      3'h0
`define SLP_RST_LINK1     7'h00
`define SLP_RST_KFRAMES   5'h00
`define SLP_RST_CS        2'h0
`define SLP_RST_SPARE     8'h00
`define SLP_RST_CHKSUM    8'h00
`define SLP_CONVS_VAL     8'h00
`define SLP_RES_VAL       5'h0D
`define SLP_TOTBITS_VAL   5'h0F
`define SLP_SAMPLES_VAL   5'h00
`define SLP_DENSCW_VAL    8'h00

// control-bits-per-sample codes
`define SLP_CS_NONE       2'h0
`define SLP_CS_ONE        2'h1
`define SLP_CS_TWO        2'h2

// frame alignment characters
`define SLP_K28_3         8'h7C
`define SLP_K28_7         8'hFC

`endif

// ---- hw/slp_fifo.v ----
// sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module slp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_core_clk,
  input  wire             i_nrst,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      count_q;
  reg              ready_q;
  wire             push;
  wire             pop;
  wire [AW:0]      count_d;

  assign push    = i_valid & ready_q;
  assign pop     = i_ready & (count_q != {(AW+1){1'b0}});
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_ready = ready_q;
  assign o_valid = (count_q != {(AW+1){1'b0}});
  assign o_data  = mem_q[rd_ptr_q];

  // storage has no reset: contents only matter once counted
  always @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

  // ready is registered so the source sees an honest full
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
      ready_q  <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_d;
      ready_q <= (count_d < DEPTH);
    end
  end
endmodule // slp_fifo

// ---- hw/slp_lfsr31.v ----
// 31-bit pseudo-random generator for tail-bit padding
`timescale 1ns/1ps
module slp_lfsr31 #(
  parameter [30:0] SEED = 31'h7FFFFFFF
) (
  input  wire       i_core_clk,
  input  wire       i_nrst,
  input  wire       i_clr,
  input  wire       i_step,
  output wire [1:0] o_bits
);
  reg [30:0] state_q;

  assign o_bits = state_q[1:0];

  // x^31 + x^28 + 1, reseeded while the link is held down
  always @(posedge i_core_clk) begin
    if (!i_nrst || i_clr) begin
      state_q <= SEED;
    end else if (i_step) begin
      state_q <= {state_q[29:0], state_q[30] ^ state_q[27]};
    end
  end
endmodule // slp_lfsr31

// ---- hw/slp_regs_top.v ----
// link parameter and sync register bank with serial port and sample path
`timescale 1ns/1ps
`include "slp_regs.vh"

// Functional notes
// - octets-per-frame reads fixed value 0x01
// - multiframe length low five bits, rest zero
// - total bits per sample read-only
// - resolution read-only, control-bit field writable
// - two spare scratch registers, reset zero
// - checksum read-only, reset zero
// - next-sync-only aligns on first pulse only
// - divider sync enable self-clears after sync when next-sync-only is set
// - pulses pass only with both enables high
// - master enable gates every sync function
// - tail bits padded from 31-bit LFSR
// - test samples replace converter samples
// - lane sync inserts K28.3 or K28.7
// - checksum is sum of parameter and spare registers modulo 256
// - converter-count bit reads zero
// - control-bit codes 00, 01, 10 used
module slp_regs_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_spi_sclk,
  input  wire        i_spi_csb_n,
  input  wire        i_spi_sdio,
  output wire        o_spi_sdio,
  output wire        o_spi_sdio_oe,
  input  wire        i_sync_pulse,
  output wire        o_div_sync,
  output wire        o_sync_buf_en,
  input  wire [13:0] i_smp_data,
  input  wire [1:0]  i_smp_flags,
  input  wire        i_smp_valid,
  output wire        o_smp_ready,
  output wire [15:0] o_tx_word,
  output wire        o_tx_valid,
  input  wire        i_tx_ready,
  output wire [7:0]  o_fa_char,
  output wire        o_fa_valid,
  output wire        o_link_pd,
  output wire        o_lane_sync_en
);
  // serial port state
  reg        sclk_q;
  reg [4:0]  bit_cnt_q;
  reg [15:0] instr_q;
  reg [7:0]  wdata_q;
  reg [7:0]  rd_byte_q;
  reg        sdio_q;
  reg        sdio_oe_q;
  // registers
  reg [2:0]  sync_q;
  reg [6:0]  link1_q;
  reg [4:0]  kframes_q;
  reg [1:0]  cs_q;
  reg [7:0]  spare1_q;
  reg [7:0]  spare2_q;
  reg [7:0]  chksum_q;
  // sync and datapath state
  reg        div_sync_q;
  reg [15:0] tx_word_q;
  reg        tx_valid_q;
  reg [7:0]  fa_char_q;
  reg        fa_valid_q;
  reg [4:0]  frame_cnt_q;
  reg [15:0] test_q;
  reg [7:0]  rd_mux;
  reg [15:0] word_d;

  wire        sclk_rise;
  wire        sclk_fall;
  wire        is_read;
  wire        wr_commit;
  wire [12:0] wr_addr;
  wire [12:0] rd_addr;
  wire [7:0]  wr_byte;
  wire [4:0]  rd_idx;
  wire        sync_hit;
  wire        sync_wr;
  wire [7:0]  chksum_d;
  wire [15:0] fifo_data;
  wire        fifo_valid;
  wire        fifo_pop;
  wire        link_pd;
  wire [1:0]  tail_bits;
  wire [7:0]  octets_val;

  // fixed one: two octets per frame with one converter and one lane, minus one
  assign octets_val = 8'h01;

  // serial port decode; pins are already synchronous to the core clock
  assign sclk_rise = i_spi_sclk & ~sclk_q & ~i_spi_csb_n;
  assign sclk_fall = ~i_spi_sclk & sclk_q & ~i_spi_csb_n;
  assign is_read   = instr_q[15];
  assign wr_addr   = instr_q[12:0];
  assign rd_addr   = {instr_q[11:0], i_spi_sdio};
  assign wr_byte   = {wdata_q[6:0], i_spi_sdio};
  assign wr_commit = sclk_rise & (bit_cnt_q == `SLP_LAST_BIT) & ~is_read;
  assign rd_idx    = `SLP_LAST_BIT - bit_cnt_q;

  // register read mux, unused bits read as zero
  always @* begin
    case (rd_addr)
      `SLP_ADDR_SYNC:    rd_mux = {5'h00, sync_q};
      `SLP_ADDR_LINK1:   rd_mux = {1'b0, link1_q};
      `SLP_ADDR_OCTETS:  rd_mux = octets_val;
      `SLP_ADDR_KFRAMES: rd_mux = {3'h0, kframes_q};
      `SLP_ADDR_CONVS:   rd_mux = `SLP_CONVS_VAL;
      `SLP_ADDR_RESCS:   rd_mux = {cs_q, 1'b0, `SLP_RES_VAL};
      `SLP_ADDR_TOTBITS: rd_mux = {3'h0, `SLP_TOTBITS_VAL};
      `SLP_ADDR_SAMPLES: rd_mux = {3'h0, `SLP_SAMPLES_VAL};
      `SLP_ADDR_DENSCW:  rd_mux = `SLP_DENSCW_VAL;
      `SLP_ADDR_SPARE1:  rd_mux = spare1_q;
      `SLP_ADDR_SPARE2:  rd_mux = spare2_q;
      `SLP_ADDR_CHKSUM:  rd_mux = chksum_q;
      default:           rd_mux = 8'h00;
    endcase
  end

  // serial port: 16-bit instruction, then one data byte, msb first
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sclk_q    <= 1'b0;
      bit_cnt_q <= 5'h00;
      instr_q   <= 16'h0000;
      wdata_q   <= 8'h00;
      rd_byte_q <= 8'h00;
      sdio_q    <= 1'b0;
      sdio_oe_q <= 1'b0;
    end else begin
      sclk_q <= i_spi_sclk;
      // deselect ends the frame and frees the sdio line
      if (i_spi_csb_n) begin
        bit_cnt_q <= 5'h00;
        sdio_oe_q <= 1'b0;
      end else begin
        // extra clocks past the 24th bit are ignored until deselect
        if (sclk_rise && bit_cnt_q != `SLP_FRAME_BITS) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q < `SLP_INSTR_BITS) begin
            instr_q <= {instr_q[14:0], i_spi_sdio};
          end else begin
            wdata_q <= wr_byte;
          end
          // capture read data once the address is complete
          if (bit_cnt_q == `SLP_INSTR_BITS - 5'h01) begin
            rd_byte_q <= rd_mux;
          end
        end
        // drive on falling edges so the master samples on rising ones
        if (sclk_fall && is_read && bit_cnt_q >= `SLP_INSTR_BITS && bit_cnt_q <= `SLP_LAST_BIT) begin
          sdio_q    <= rd_byte_q[rd_idx[2:0]];
          sdio_oe_q <= 1'b1;
        end
      end
    end
  end

  // divider sync gating: master and divider enables must both be high
  assign sync_hit = i_sync_pulse & sync_q[`SLP_SYNC_MASTER] & sync_q[`SLP_SYNC_DIV_EN];
  assign sync_wr  = wr_commit & (wr_addr == `SLP_ADDR_SYNC);

  // writable registers; read-only fields other than the checksum have no storage
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sync_q    <= `SLP_RST_SYNC;
      link1_q   <= `SLP_RST_LINK1;
      kframes_q <= `SLP_RST_KFRAMES;
      cs_q      <= `SLP_RST_CS;
      spare1_q  <= `SLP_RST_SPARE;
      spare2_q  <= `SLP_RST_SPARE;
    end else begin
      // a software write wins over the self-clear in the same cycle
      if (sync_wr) begin
        sync_q <= wr_byte[2:0];
      end else if (sync_hit && sync_q[`SLP_SYNC_NEXT]) begin
        sync_q[`SLP_SYNC_DIV_EN] <= 1'b0;
      end
      // read-only and unmapped offsets fall to the default
      if (wr_commit) begin
        case (wr_addr)
          `SLP_ADDR_LINK1:   link1_q   <= wr_byte[6:0];
          `SLP_ADDR_KFRAMES: kframes_q <= wr_byte[4:0];
          `SLP_ADDR_RESCS:   cs_q      <= wr_byte[7:6];
          `SLP_ADDR_SPARE1:  spare1_q  <= wr_byte;
          `SLP_ADDR_SPARE2:  spare2_q  <= wr_byte;
          default:           ;
        endcase
      end
    end
  end

  // checksum tracks the parameter and spare registers, one cycle behind
  assign chksum_d = octets_val + {3'h0, kframes_q} + `SLP_CONVS_VAL + {3'h0, `SLP_RES_VAL} + {6'h00, cs_q}
                  + {3'h0, `SLP_TOTBITS_VAL} + {3'h0, `SLP_SAMPLES_VAL} + `SLP_DENSCW_VAL
                  + spare1_q + spare2_q;

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      chksum_q   <= `SLP_RST_CHKSUM;
      div_sync_q <= 1'b0;
    end else begin
      chksum_q   <= chksum_d;
      div_sync_q <= sync_hit;
    end
  end

  // sample buffer; full back-pressures the converter side
  slp_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     ({i_smp_data, i_smp_flags}),
    .i_valid    (i_smp_valid),
    .o_ready    (o_smp_ready),
    .o_data     (fifo_data),
    .o_valid    (fifo_valid),
    .i_ready    (fifo_pop)
  );

  // powered-down link holds its path in reset and stops draining
  assign link_pd  = link1_q[`SLP_L1_PD];
  assign fifo_pop = fifo_valid & ~link_pd & (~tx_valid_q | i_tx_ready);

  slp_lfsr31 u_lfsr (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_clr      (link_pd),
    .i_step     (fifo_pop),
    .o_bits     (tail_bits)
  );

  // build the 16-bit link sample: 14 data bits, control bits, tail
  always @* begin
    word_d = 16'h0000;
    case (cs_q)
      `SLP_CS_NONE: word_d = {fifo_data[15:2], 2'h0};
      `SLP_CS_ONE:  word_d = {fifo_data[15:1], 1'b0};
      `SLP_CS_TWO:  word_d = fifo_data;
      default:      word_d = {fifo_data[15:2], 2'h0}; // unused code sends no control bits
    endcase
    if (link1_q[`SLP_L1_TAIL]) begin
      case (cs_q)
        `SLP_CS_ONE: word_d[0]   = tail_bits[0];
        // both flag bits in use, nothing left to pad
        `SLP_CS_TWO: word_d[1:0] = fifo_data[1:0];
        default:     word_d[1:0] = tail_bits;
      endcase
    end
    if (link1_q[`SLP_L1_TEST]) begin
      word_d = test_q;
    end
  end

  // output stage; samples drained in test mode are discarded on purpose
  always @(posedge i_core_clk) begin
    if (!i_nrst || link_pd) begin
      tx_word_q   <= 16'h0000;
      tx_valid_q  <= 1'b0;
      fa_char_q   <= 8'h00;
      fa_valid_q  <= 1'b0;
      frame_cnt_q <= 5'h00;
      test_q      <= 16'h0000;
    end else if (fifo_pop) begin
      tx_word_q  <= word_d;
      tx_valid_q <= 1'b1;
      // one word is one frame; last frame of a multiframe gets K28.3
      fa_valid_q <= link1_q[`SLP_L1_LANE_SYNC] & ~link1_q[`SLP_L1_FA_DIS];
      fa_char_q  <= (frame_cnt_q == kframes_q) ? `SLP_K28_3 : `SLP_K28_7;
      // counter restarts from frame zero after every power-down
      frame_cnt_q <= (frame_cnt_q == kframes_q) ? 5'h00 : frame_cnt_q + 5'h01;
      // ramp also restarts from zero after power-down
      if (link1_q[`SLP_L1_TEST]) begin
        test_q <= test_q + 16'h0001;
      end
    end else if (i_tx_ready) begin
      tx_valid_q <= 1'b0;
      fa_valid_q <= 1'b0;
    end
  end

  assign o_spi_sdio     = sdio_q;
  assign o_spi_sdio_oe  = sdio_oe_q;
  assign o_div_sync     = div_sync_q;
  assign o_sync_buf_en  = sync_q[`SLP_SYNC_MASTER];
  assign o_tx_word      = tx_word_q;
  assign o_tx_valid     = tx_valid_q;
  assign o_fa_char      = fa_char_q;
  assign o_fa_valid     = fa_valid_q;
  assign o_link_pd      = link1_q[`SLP_L1_PD];
  assign o_lane_sync_en = link1_q[`SLP_L1_LANE_SYNC];
endmodule // slp_regs_top

// ---- bench/slp_regs_assertions.sv ----
// checker on the top ports of the link register bank
`timescale 1ns/1ps
`include "slp_regs.vh"
module slp_regs_chk (
  input logic        i_core_clk,
  input logic        i_nrst,
  input logic        i_spi_csb_n,
  input logic        o_spi_sdio_oe,
  input logic        i_sync_pulse,
  input logic        o_div_sync,
  input logic        o_sync_buf_en,
  input logic [15:0] o_tx_word,
  input logic        o_tx_valid,
  input logic        i_tx_ready,
  input logic [7:0]  o_fa_char,
  input logic        o_fa_valid,
  input logic        o_link_pd
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // divider pulse only from a pulse seen with the master enable up
  AST_DIV_GATE: assert property (o_div_sync |-> $past(i_sync_pulse) && $past(o_sync_buf_en))
    else $error("divider pulse without gated sync input");
  AST_BUF_GATE: assert property (!o_sync_buf_en |=> !o_div_sync)
    else $error("divider pulse with master enable low");
  // a stalled word and its alignment char stay put unless the link goes down
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=>
    o_link_pd || (o_tx_valid && $stable(o_tx_word) && $stable(o_fa_char)))
    else $error("stalled word changed");
  AST_PD_CLEAR: assert property (o_link_pd |=> !o_tx_valid)
    else $error("word valid while link powered down");
  AST_FA_CODE: assert property (o_fa_valid |-> o_fa_char == `SLP_K28_3 || o_fa_char == `SLP_K28_7)
    else $error("alignment char not a legal code");
  AST_FA_WORD: assert property (o_fa_valid |-> o_tx_valid)
    else $error("alignment char without a word");
  // serial data is only driven inside a selected transaction
  AST_OE_CS: assert property (i_spi_csb_n |=> !o_spi_sdio_oe)
    else $error("sdio driven after deselect");
  AST_OE_START: assert property ($rose(o_spi_sdio_oe) |-> !i_spi_csb_n)
    else $error("sdio driver enabled while deselected");
endmodule // slp_regs_chk

bind slp_regs_top slp_regs_chk u_chk (.i_core_clk, .i_nrst, .i_spi_csb_n, .o_spi_sdio_oe, .i_sync_pulse,
  .o_div_sync, .o_sync_buf_en, .o_tx_word, .o_tx_valid, .i_tx_ready, .o_fa_char, .o_fa_valid, .o_link_pd);

// ---- bench/slp_link_sink.sv ----
// receiver-side model taking link words
`timescale 1ns/1ps
module slp_link_sink (
  input  logic        i_core_clk,
  input  logic        i_nrst,
  input  logic        i_slow,
  input  logic [15:0] i_word,
  input  logic        i_valid,
  input  logic        i_fa_valid,
  input  logic [7:0]  i_fa_char,
  output logic        o_ready
);
  logic [15:0] got[$];
  logic        tog_q;
  logic [7:0]  fa_prev = 8'h00;
  logic [7:0]  fa_last = 8'h00;
  int          fa_n = 0;
  // slow mode stalls every other cycle so held words are exercised
  always @(posedge i_core_clk) begin
    tog_q <= i_nrst ? ~tog_q : 1'h0;
    if (i_nrst && i_valid && o_ready) got.push_back(i_word);
    if (i_nrst && i_valid && o_ready && i_fa_valid) begin
      fa_n    <= fa_n + 1;
      fa_prev <= fa_last;
      fa_last <= i_fa_char;
    end
  end
  // never ready in reset; a receiver takes nothing then
  assign o_ready = i_nrst && (!i_slow || tog_q);
endmodule // slp_link_sink

// ---- bench/slp_regs_top_tb.sv ----
// self-checking bench for the link register bank
`timescale 1ns/1ps
module slp_regs_top_tb;
  logic        i_core_clk = 1'h0;
  logic        i_nrst = 1'h0;
  logic        i_spi_sclk = 1'h0;
  logic        i_spi_csb_n = 1'h1;
  logic        m_sdio = 1'h0;
  logic        i_sync_pulse = 1'h0;
  logic [13:0] i_smp_data = 14'h0000;
  logic [1:0]  i_smp_flags = 2'h0;
  logic        i_smp_valid = 1'h0;
  logic        slow = 1'h1;
  wire         i_spi_sdio, o_spi_sdio, o_spi_sdio_oe, o_div_sync, o_sync_buf_en, o_smp_ready;
  wire         o_tx_valid, i_tx_ready, o_fa_valid, o_link_pd, o_lane_sync_en;
  wire  [15:0] o_tx_word;
  wire  [7:0]  o_fa_char;
  logic [7:0]  v;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  // address, reset value, value written, value read back
  logic [12:0] ta [10] = '{13'h6F, 13'h70, 13'h71, 13'h72, 13'h73, 13'h74, 13'h76, 13'h77, 13'h10, 13'h78};
  logic [7:0]  tr [10] = '{8'h01, 8'h00, 8'h00, 8'h0D, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1D};
  logic [7:0]  tw [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'hFF};
  logic [7:0]  te [10] = '{8'h01, 8'h1F, 8'h00, 8'h8D, 8'h0F, 8'h00, 8'hA5, 8'h5A, 8'h00, 8'h3D};

  // shared sdio wire: the device wins while its enable is up
  assign i_spi_sdio = o_spi_sdio_oe ? o_spi_sdio : m_sdio;

  slp_regs_top DUT (.i_core_clk, .i_nrst, .i_spi_sclk, .i_spi_csb_n, .i_spi_sdio, .o_spi_sdio, .o_spi_sdio_oe,
    .i_sync_pulse, .o_div_sync, .o_sync_buf_en, .i_smp_data, .i_smp_flags, .i_smp_valid, .o_smp_ready,
    .o_tx_word, .o_tx_valid, .i_tx_ready, .o_fa_char, .o_fa_valid, .o_link_pd, .o_lane_sync_en);
  slp_link_sink sink (.i_core_clk, .i_nrst, .i_slow(slow), .i_word(o_tx_word), .i_valid(o_tx_valid),
    .i_fa_valid(o_fa_valid), .i_fa_char(o_fa_char), .o_ready(i_tx_ready));

  initial forever #4 i_core_clk = ~i_core_clk;
  // hang guard, well above the expected run length
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task close_out;
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one framed transaction; sclk half period of 3 core cycles keeps the sampler happy
  task spi(input logic rd, input logic [12:0] a, input logic [7:0] wd);
    logic [23:0] f;
    f = {rd, 2'h0, a, wd};
    i_spi_csb_n = 1'h0;
    for (int i = 0; i < 24; i++) begin
      m_sdio = (rd && i > 15) ? i[0] : f[23-i];
      repeat (3) @(negedge i_core_clk);
      if (i > 15) v = {v[6:0], i_spi_sdio};
      i_spi_sclk = 1'h1;
      repeat (3) @(negedge i_core_clk);
      i_spi_sclk = 1'h0;
    end
    repeat (3) @(negedge i_core_clk);
    i_spi_csb_n = 1'h1;
    repeat (3) @(negedge i_core_clk);
  endtask

  task wr(input logic [12:0] a, input logic [7:0] d8);
    spi(1'h0, a, d8);
  endtask

  task rdc(input logic [12:0] a, input logic [7:0] e);
    spi(1'h1, a, 8'h00);
    chk($sformatf("reg_%h", a), {8'h00, v}, {8'h00, e});
  endtask

  task sp(input logic e);
    i_sync_pulse = 1'h1;
    @(negedge i_core_clk);
    i_sync_pulse = 1'h0;
    chk("div_sync", o_div_sync, e);
    @(negedge i_core_clk);
  endtask

  // caller makes sure ready is up; valid stays high for back-to-back use
  task push(input logic [13:0] d, input logic [1:0] fl);
    i_smp_data = d;
    i_smp_flags = fl;
    i_smp_valid = 1'h1;
    @(negedge i_core_clk);
  endtask

  task waitn(input int w);
    int k;
    k = 0;
    while (sink.got.size() < w && k < 400) begin
      @(negedge i_core_clk);
      k++;
    end
    chk("word_count", 16'(sink.got.size()), 16'(w));
  endtask

  // main sequence
  initial begin
    repeat (10) @(negedge i_core_clk);
    i_nrst = 1'h1;
    repeat (2) @(negedge i_core_clk);
    chk("smp_ready", o_smp_ready, 1'h1);
    for (int i = 0; i < 10; i++) rdc(ta[i], tr[i]);
    wr(13'h60, 8'h01);
    chk("link_pd", o_link_pd, 1'h1);
    for (int i = 0; i < 10; i++) wr(ta[i], tw[i]);
    for (int i = 0; i < 10; i++) rdc(ta[i], te[i]);
    wr(13'h3A, 8'h01);
    chk("sync_buf_en", o_sync_buf_en, 1'h1);
    sp(1'h0);
    wr(13'h3A, 8'h03);
    sp(1'h1);
    sp(1'h1);
    wr(13'h3A, 8'h07);
    sp(1'h1);
    rdc(13'h3A, 8'h05);
    sp(1'h0);
    wr(13'h3A, 8'h06);
    sp(1'h0);
    wr(13'h3A, 8'h00);
    // fill the buffer while the link is down, then drain into a stalling sink
    for (n = 0; n < 20 && o_smp_ready === 1'h1; n++) push(14'h1000 + 14'(n), 2'(n));
    i_smp_valid = 1'h0;
    chk("fill", n[15:0], 16'h0010);
    wr(13'h60, 8'h10);
    chk("lane_sync", o_lane_sync_en, 1'h1);
    waitn(16);
    for (int i = 0; i < 16; i++) chk("word", sink.got[i], {14'h1000 + 14'(i), 2'(i)});
    chk("fa_seen", sink.fa_n > 0, 1'h1);
    for (int c = 0; c < 3; c++) begin
      wr(13'h60, 8'h01);
      wr(13'h72, {2'(c), 6'h00});
      rdc(13'h72, {2'(c), 6'h0D});
      wr(13'h60, 8'h10);
      push(14'h2000, 2'h3);
      i_smp_valid = 1'h0;
      waitn(17 + c);
      chk("cs_word", sink.got[16+c], {14'h2000, c != 0, c == 2});
    end
    // test ramp with alignment chars switched off
    wr(13'h60, 8'h32);
    for (int i = 0; i < 3; i++) push(14'h3000, 2'h0);
    i_smp_valid = 1'h0;
    waitn(22);
    chk("ramp0", sink.got[19], 16'h0000);
    chk("ramp1", sink.got[20] - sink.got[19], 16'h0001);
    chk("ramp2", sink.got[21] - sink.got[20], 16'h0001);
    chk("fa_off", 16'(sink.fa_n), 16'h0013);
    // tail padding from the reseeded generator, two-frame multiframe
    wr(13'h60, 8'h01);
    wr(13'h72, 8'h00);
    wr(13'h70, 8'h01);
    rdc(13'h78, 8'h1D);
    wr(13'h60, 8'h50);
    push(14'h2AAA, 2'h0);
    push(14'h2AAA, 2'h0);
    i_smp_valid = 1'h0;
    waitn(24);
    chk("tail0", sink.got[22], {14'h2AAA, 2'h3});
    chk("tail1", sink.got[23], {14'h2AAA, 2'h2});
    chk("fa_mid", 16'(sink.fa_prev), 16'h00FC);
    chk("fa_end", 16'(sink.fa_last), 16'h007C);
    close_out();
  end
endmodule // slp_regs_top_tb
